/* isp_ctrl.sv */
// Operation
// - SDA changes only while SCL low
// - SDA falling with SCL high is START
// - SDA rising with SCL high is STOP
// - Only master generates START and STOP
// - Eight bits MSB first, then ack slot
// - Master clocks ack pulse, releases SDA
// - Master NACKs final read byte
// - First byte: address plus direction bit; HS commands send the master code before it
// - Write: index byte, then i_cmd_count data bytes
// - Read needs preceding index write phase
`timescale 1ns/10ps
`include "isp_cfg.svh"

module isp_ctrl
    import isp_pkg::*;
#(
    parameter int CLK_HZ = `ISP_CLK_HZ,
    parameter int SCL_HZ = `ISP_SCL_HZ,
    parameter int HS_SCL_HZ = `ISP_HS_SCL_HZ,
    parameter int MAX_BYTES = 4,
    parameter int CNT_W = 3,
    parameter int DIV_W = 8
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic i_cmd_read,
    input wire logic i_cmd_hs,
    input wire logic [7:0] i_cmd_index,
    input wire logic [CNT_W-1:0] i_cmd_count,
    input wire logic [8*MAX_BYTES-1:0] i_cmd_wdata,
    input wire logic i_dev_reset,
    output logic o_hardware_reset_n_pin,
    input wire logic i_scl,
    output logic o_scl_o,
    output logic o_scl_oe,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_busy,
    output logic o_done,
    output logic o_nack,
    output logic [7:0] o_rd_data
);

    // Quarter period counts; rounded up so no rate is exceeded
    localparam int STD_Q = (CLK_HZ + `ISP_QUARTERS * SCL_HZ - 1) / (`ISP_QUARTERS * SCL_HZ);
    localparam int HS_Q = (CLK_HZ + `ISP_QUARTERS * HS_SCL_HZ - 1) / (`ISP_QUARTERS * HS_SCL_HZ);
    localparam logic [DIV_W-1:0] STD_RELOAD = DIV_W'(STD_Q - 1);
    localparam logic [DIV_W-1:0] HS_RELOAD = DIV_W'(HS_Q - 1);

    isp_state_t state_reg;
    isp_stage_t stage_reg;
    logic [1:0] phase_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic ack_bit_reg;
    logic read_reg;
    logic hs_reg;
    logic [7:0] index_reg;
    logic [CNT_W-1:0] count_reg;
    logic [8*MAX_BYTES-1:0] wdata_reg;
    logic scl_low_reg;
    logic sda_low_reg;
    logic [DIV_W-1:0] div_reg;
    logic [1:0] pin_sync;
    logic scl_in;
    logic sda_in;
    logic tick;
    logic stretch;
    logic adv;
    logic expect_ack;

    // Bus pins pass two flops before any use
    isp_sync2 #(.WIDTH(2)) u_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_d({i_scl, i_sda}),
        .o_q(pin_sync)
    );
    assign scl_in = pin_sync[1];
    assign sda_in = pin_sync[0];

    // Quarter-period divider; the master makes SCL from its own clock
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_reg <= '0;
        end else if (div_reg == '0) begin
            div_reg <= hs_reg ? HS_RELOAD : STD_RELOAD;
        end else begin
            div_reg <= div_reg - 1'b1;
        end
    end

    // Hold the high phase while a target stretches SCL
    assign tick = (div_reg == '0);
    assign stretch = (phase_reg == `ISP_PH_SAMPLE) && !scl_low_reg && !scl_in;
    assign adv = tick && !stretch && (state_reg != ST_IDLE);
    // Master code and the read byte are answered with NACK by design
    assign expect_ack = (stage_reg != STG_MCODE) && (stage_reg != STG_RDATA);

    // Target reset pin; held low while this controller is reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hardware_reset_n_pin <= 1'b0;
        end else begin
            o_hardware_reset_n_pin <= !i_dev_reset;
        end
    end

    // No new command while the target is held in reset: it would never answer
    assign o_cmd_ready = (state_reg == ST_IDLE) && o_hardware_reset_n_pin && !i_dev_reset;

    // Transfer engine
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_IDLE;
            stage_reg <= STG_ADDR;
            phase_reg <= `ISP_PH_SET;
            bit_cnt_reg <= `ISP_BIT_FIRST;
            tx_reg <= `ISP_IDLE_BYTE;
            rx_reg <= '0;
            ack_bit_reg <= 1'b1;
            read_reg <= 1'b0;
            hs_reg <= 1'b0;
            index_reg <= '0;
            count_reg <= '0;
            wdata_reg <= '0;
            scl_low_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            o_done <= 1'b0;
            o_nack <= 1'b0;
            o_rd_data <= '0;
        end else begin
            o_done <= 1'b0;
            if (adv) begin
                phase_reg <= phase_reg + 2'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (i_cmd_valid && o_cmd_ready) begin
                        state_reg <= ST_START;
                        phase_reg <= `ISP_PH_SET;
                        read_reg <= i_cmd_read;
                        index_reg <= i_cmd_index;
                        count_reg <= i_cmd_count;
                        wdata_reg <= i_cmd_wdata;
                        o_nack <= 1'b0;
                        hs_reg <= 1'b0;
                        if (i_cmd_hs) begin
                            // Master code first, at the slow rate
                            stage_reg <= STG_MCODE;
                            tx_reg <= `ISP_MASTER_CODE;
                        end else begin
                            stage_reg <= STG_ADDR;
                            tx_reg <= {`ISP_TARGET_ADDR, `ISP_DIR_WRITE};
                        end
                    end
                end
                ST_START: begin
                    if (adv) begin
                        case (phase_reg)
                            `ISP_PH_SET: sda_low_reg <= 1'b0;
                            `ISP_PH_RISE: scl_low_reg <= 1'b0;
                            // SDA falls with SCL high; also serves as repeated START
                            `ISP_PH_SAMPLE: sda_low_reg <= 1'b1;
                            default: begin
                                scl_low_reg <= 1'b1;
                                state_reg <= ST_BYTE;
                                bit_cnt_reg <= `ISP_BIT_FIRST;
                            end
                        endcase
                    end
                end
                ST_BYTE: begin
                    if (adv) begin
                        case (phase_reg)
                            `ISP_PH_SET: begin
                                // Data set while SCL is low; ack slot and read bits released
                                if (bit_cnt_reg != `ISP_ACK_SLOT && stage_reg != STG_RDATA) begin
                                    sda_low_reg <= !tx_reg[7];
                                end else begin
                                    sda_low_reg <= 1'b0;
                                end
                            end
                            `ISP_PH_RISE: scl_low_reg <= 1'b0;
                            `ISP_PH_SAMPLE: begin
                                if (bit_cnt_reg != `ISP_ACK_SLOT) begin
                                    rx_reg <= {rx_reg[6:0], sda_in};
                                end else begin
                                    ack_bit_reg <= sda_in;
                                end
                            end
                            default: begin
                                scl_low_reg <= 1'b1;
                                if (bit_cnt_reg != `ISP_ACK_SLOT) begin
                                    bit_cnt_reg <= bit_cnt_reg + `ISP_BIT_STEP;
                                    tx_reg <= {tx_reg[6:0], 1'b0};
                                end else begin
                                    bit_cnt_reg <= `ISP_BIT_FIRST;
                                    if (expect_ack && ack_bit_reg) begin
                                        // Missing ACK (foreign address or silent target) aborts
                                        o_nack <= 1'b1;
                                        state_reg <= ST_STOP;
                                    end else begin
                                        case (stage_reg)
                                            STG_MCODE: begin
                                                // Repeated START, then everything at high speed
                                                hs_reg <= 1'b1;
                                                state_reg <= ST_START;
                                                stage_reg <= STG_ADDR;
                                                tx_reg <= {`ISP_TARGET_ADDR, `ISP_DIR_WRITE};
                                            end
                                            STG_ADDR: begin
                                                stage_reg <= STG_INDEX;
                                                tx_reg <= index_reg;
                                            end
                                            STG_INDEX: begin
                                                if (read_reg) begin
                                                    // Index set; readdress for reading
                                                    state_reg <= ST_START;
                                                    stage_reg <= STG_RADDR;
                                                    tx_reg <= {`ISP_TARGET_ADDR, `ISP_DIR_READ};
                                                end else if (count_reg == '0) begin
                                                    state_reg <= ST_STOP;
                                                end else begin
                                                    stage_reg <= STG_DATA;
                                                    tx_reg <= wdata_reg[7:0];
                                                    wdata_reg <= wdata_reg >> `ISP_BYTE_W;
                                                    count_reg <= count_reg - 1'b1;
                                                end
                                            end
                                            STG_DATA: begin
                                                if (count_reg == '0) begin
                                                    state_reg <= ST_STOP;
                                                end else begin
                                                    // Next byte lands in the next register
                                                    tx_reg <= wdata_reg[7:0];
                                                    wdata_reg <= wdata_reg >> `ISP_BYTE_W;
                                                    count_reg <= count_reg - 1'b1;
                                                end
                                            end
                                            STG_RADDR: begin
                                                stage_reg <= STG_RDATA;
                                                tx_reg <= `ISP_IDLE_BYTE;
                                            end
                                            STG_RDATA: begin
                                                // One byte per read; index never advances
                                                o_rd_data <= rx_reg;
                                                state_reg <= ST_STOP;
                                            end
                                            default: state_reg <= ST_STOP;
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                end
                ST_STOP: begin
                    if (adv) begin
                        case (phase_reg)
                            `ISP_PH_SET: sda_low_reg <= 1'b1;
                            `ISP_PH_RISE: scl_low_reg <= 1'b0;
                            // SDA rises with SCL high
                            `ISP_PH_SAMPLE: sda_low_reg <= 1'b0;
                            default: begin
                                state_reg <= ST_IDLE;
                                hs_reg <= 1'b0;
                                o_done <= 1'b1;
                            end
                        endcase
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Open-drain pins: only ever pulled low
    assign o_scl_o = 1'b0;
    assign o_sda_o = 1'b0;
    assign o_scl_oe = scl_low_reg;
    assign o_sda_oe = sda_low_reg;
    assign o_busy = (state_reg != ST_IDLE);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_sda_stable;
        $changed(sda_low_reg) && !scl_low_reg |-> (state_reg == ST_START) || (state_reg == ST_STOP);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("SDA moved while SCL high");

    property p_start_cond;
        $rose(sda_low_reg) && !scl_low_reg |-> state_reg == ST_START ##1 state_reg == ST_START;
    endproperty
    a_start_cond: assert property (p_start_cond) else $error("SDA fell with SCL high outside START");

    property p_stop_cond;
        $fell(sda_low_reg) && !scl_low_reg |-> state_reg == ST_STOP;
    endproperty
    a_stop_cond: assert property (p_stop_cond) else $error("SDA rose with SCL high outside STOP");

    // Cycles since the STOP edge; counted, since a quarter at slow rates is too long for a delay range
    localparam int STOP_LIMIT = (STD_Q > HS_Q) ? STD_Q : HS_Q;
    logic [DIV_W:0] stop_wait_reg;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stop_wait_reg <= '0;
        end else if (state_reg != ST_STOP) begin
            stop_wait_reg <= '0;
        end else if (!scl_low_reg && !sda_low_reg) begin
            stop_wait_reg <= stop_wait_reg + 1'b1;
        end
    end

    property p_stop_done;
        state_reg == ST_STOP |-> stop_wait_reg < STOP_LIMIT;
    endproperty
    a_stop_done: assert property (p_stop_done) else $error("STOP not followed by done");

    property p_busy_start;
        $rose(o_busy) |-> state_reg == ST_START && !sda_low_reg;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("Busy without START");

    property p_done_after_stop;
        o_done |-> !o_busy && !sda_low_reg && !scl_low_reg && $past(state_reg) == ST_STOP;
    endproperty
    a_done_after_stop: assert property (p_done_after_stop) else $error("Done without clean STOP");

    property p_ack_release;
        state_reg == ST_BYTE && bit_cnt_reg == `ISP_ACK_SLOT && !scl_low_reg |-> !sda_low_reg;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("Master drove SDA in ack slot");

    property p_read_release;
        state_reg == ST_BYTE && stage_reg == STG_RDATA && phase_reg != `ISP_PH_SET |-> !sda_low_reg;
    endproperty
    a_read_release: assert property (p_read_release) else $error("Master drove SDA during read byte");

    property p_reset_refuse;
        (!o_hardware_reset_n_pin || i_dev_reset) && !o_busy |=> !o_busy;
    endproperty
    a_reset_refuse: assert property (p_reset_refuse) else $error("Command accepted during target reset");

    property p_byte_start;
        state_reg == ST_BYTE && $past(state_reg) == ST_START |-> bit_cnt_reg == `ISP_BIT_FIRST && scl_low_reg;
    endproperty
    a_byte_start: assert property (p_byte_start) else $error("Byte did not start at bit zero");

    property p_hs_after_mcode;
        $rose(hs_reg) |-> state_reg == ST_START && stage_reg == STG_ADDR;
    endproperty
    a_hs_after_mcode: assert property (p_hs_after_mcode) else $error("High speed without repeated START");

endmodule

/* isp_cfg.svh */
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH

// Bus addressing of the target port
`define ISP_TARGET_ADDR 7'h60
`define ISP_DIR_WRITE 1'b0
`define ISP_DIR_READ 1'b1
// High-speed entry code, answered with NACK by every target
`define ISP_MASTER_CODE 8'h08

// Rates in Hz, and quarters per SCL period
`define ISP_CLK_HZ 100000000
`define ISP_SCL_HZ 400000
`define ISP_HS_SCL_HZ 3400000
`define ISP_QUARTERS 4

// Bit slot bookkeeping
`define ISP_ACK_SLOT 4'h8
`define ISP_BIT_FIRST 4'h0
`define ISP_BIT_STEP 4'h1
`define ISP_BYTE_W 8
`define ISP_IDLE_BYTE 8'hff

// Quarter phases of one SCL period
`define ISP_PH_SET 2'h0
`define ISP_PH_RISE 2'h1
`define ISP_PH_SAMPLE 2'h2
`define ISP_PH_FALL 2'h3

`endif

/* isp_pkg.sv */
package isp_pkg;

    // Transfer engine states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_BYTE  = 4'b0100,
        ST_STOP  = 4'b1000
    } isp_state_t;

    // Which byte of the sequence is on the wire
    typedef enum logic [5:0] {
        STG_MCODE = 6'b000001,
        STG_ADDR  = 6'b000010,
        STG_INDEX = 6'b000100,
        STG_DATA  = 6'b001000,
        STG_RADDR = 6'b010000,
        STG_RDATA = 6'b100000
    } isp_stage_t;

endpackage

/* isp_sync2.sv */
`timescale 1ns/10ps

module isp_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // Two stages; only the second is visible, idle bus level is high
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else begin
            meta_reg <= i_d;
            sync_reg <= meta_reg;
        end
    end

    assign o_q = sync_reg;

endmodule

/* isp_tgt_model.sv */
`timescale 1ns/10ps

module isp_tgt_model (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_hardware_reset_n_pin,
    input wire logic [6:0] i_addr,
    input wire logic i_stretch,
    output logic o_scl_pull,
    output logic o_sda_pull
);
    logic [7:0] regs [0:255];
    logic [7:0] idx;
    logic [7:0] sh;
    logic pull;
    logic active;
    logic matched;
    logic rd;
    logic tx;
    logic ackslot;
    int bitn;
    int nbyte;

    // Seeded pattern so a read of a stale register still shows
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h5a;
        end
        {idx, sh, pull, active, matched, rd, tx, ackslot} = '0;
        bitn = 0;
        nbyte = 0;
        o_scl_pull = 1'b0;
    end

    // Data line only ever pulled low, never while held in reset
    assign o_sda_pull = pull & i_hardware_reset_n_pin;

    // START and repeated START both restart address reception
    always @(negedge i_sda) begin
        if (i_scl === 1'b1) begin
            active = 1'b1;
            bitn = 0;
            nbyte = 0;
            {matched, rd, tx, ackslot, pull} = '0;
        end
    end

    // STOP frees the bus
    always @(posedge i_sda) begin
        if (i_scl === 1'b1) begin
            active = 1'b0;
            pull = 1'b0;
        end
    end

    // Bits taken on SCL rising only, no other timing source
    always @(posedge i_scl) begin
        if (active && !ackslot && bitn < 8) begin
            sh = tx ? sh : {sh[6:0], i_sda};
            bitn++;
        end
    end

    // All drive changes happen while SCL is low
    always @(negedge i_scl) begin
        if (active && bitn == 8 && !ackslot) begin
            ackslot = 1'b1;
            pull = 1'b0;
            if (!tx) begin
                if (nbyte == 0) begin
                    matched = (sh[7:1] == i_addr);
                    rd = sh[0];
                end else if (matched && !rd) begin
                    if (nbyte == 1) begin
                        idx = sh;
                    end else begin
                        regs[idx] = sh;
                        idx = idx + 8'h01;
                    end
                end
                pull = matched;
            end
            nbyte++;
        end else if (active && ackslot) begin
            ackslot = 1'b0;
            bitn = 0;
            tx = matched && rd && nbyte == 1;
            pull = tx & ~regs[idx][7];
            // Slow target: hold the clock low a while
            if (i_stretch) begin
                o_scl_pull = 1'b1;
                #200;
                o_scl_pull = 1'b0;
            end
        end else if (active && tx && bitn < 8) begin
            pull = ~regs[idx][7 - bitn];
        end
    end
endmodule

/* isp_ctrl_tb.sv */
`timescale 1ns/10ps

module isp_ctrl_tb;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_cmd_valid = 1'b0;
    logic i_cmd_read = 1'b0;
    logic i_cmd_hs = 1'b0;
    logic [7:0] i_cmd_index = 8'h00;
    logic [2:0] i_cmd_count = 3'h0;
    logic [31:0] i_cmd_wdata = 32'h0;
    logic i_dev_reset = 1'b0;
    logic [6:0] tgt_addr = 7'h60;
    logic stretch = 1'b0;
    logic o_cmd_ready, o_hardware_reset_n_pin, o_scl_oe, o_sda_oe, o_busy, o_done, o_nack;
    logic [7:0] o_rd_data;
    logic scl_pull, sda_pull, scl_w, sda_w, scl_o, sda_o;
    int errors = 0;
    int tests_run = 0;

    // Open-drain wires with pull-ups
    assign scl_w = !(o_scl_oe | scl_pull);
    assign sda_w = !(o_sda_oe | sda_pull);

    always #5 i_clk = ~i_clk;

    // Quarter of two cycles keeps the run short
    isp_ctrl #(.SCL_HZ(12500000), .HS_SCL_HZ(12500000)) u_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
        .i_cmd_read(i_cmd_read), .i_cmd_hs(i_cmd_hs), .i_cmd_index(i_cmd_index), .i_cmd_count(i_cmd_count),
        .i_cmd_wdata(i_cmd_wdata), .i_dev_reset(i_dev_reset), .o_hardware_reset_n_pin(o_hardware_reset_n_pin),
        .i_scl(scl_w), .o_scl_o(scl_o), .o_scl_oe(o_scl_oe), .i_sda(sda_w), .o_sda_o(sda_o), .o_sda_oe(o_sda_oe),
        .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack), .o_rd_data(o_rd_data));

    isp_tgt_model u_tgt (
        .i_scl(scl_w), .i_sda(sda_w), .i_hardware_reset_n_pin(o_hardware_reset_n_pin), .i_addr(tgt_addr),
        .i_stretch(stretch), .o_scl_pull(scl_pull), .o_sda_pull(sda_pull));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One command through the handshake, every wait bounded
    task automatic run_cmd(input logic rd, input logic hs, input logic [7:0] idx, input logic [2:0] cnt,
            input logic [31:0] wd, input logic exp_nack);
        int n;
        n = 0;
        while (o_cmd_ready !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(o_cmd_ready, 1'b1);
        check({scl_o, sda_o}, 8'h00);
        {i_cmd_read, i_cmd_hs, i_cmd_index, i_cmd_count, i_cmd_wdata} = {rd, hs, idx, cnt, wd};
        i_cmd_valid = 1'b1;
        @(posedge i_clk);
        #1;
        i_cmd_valid = 1'b0;
        check(o_busy, 1'b1);
        while (o_done !== 1'b1 && n < 5000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (o_done !== 1'b1) begin
            errors++;
            end_of_test();
        end
        check(o_nack, exp_nack);
        check({sda_w, scl_w}, 8'h03);
    endtask

    // Burst write lands in consecutive registers
    task automatic sc_burst;
        run_cmd(1'b0, 1'b0, 8'h10, 3'd4, 32'h44332211, 1'b0);
        for (int k = 0; k < 4; k++) begin
            check(u_tgt.regs[8'h10 + k], 8'(8'h11 * (k + 1)));
        end
    endtask

    // Back-to-back index write then reads, with a stretching target
    task automatic sc_read;
        run_cmd(1'b0, 1'b0, 8'h13, 3'd0, 32'h0, 1'b0);
        stretch = 1'b1;
        run_cmd(1'b1, 1'b0, 8'h12, 3'd0, 32'h0, 1'b0);
        check(o_rd_data, 8'h33);
        run_cmd(1'b1, 1'b0, 8'h40, 3'd0, 32'h0, 1'b0);
        check(o_rd_data, 8'h1a);
        stretch = 1'b0;
    endtask

    // High-speed entry via master code, then write and read back
    task automatic sc_hs;
        run_cmd(1'b0, 1'b1, 8'h21, 3'd1, 32'h000000a5, 1'b0);
        check(u_tgt.regs[8'h21], 8'ha5);
        run_cmd(1'b1, 1'b1, 8'h21, 3'd0, 32'h0, 1'b0);
        check(o_rd_data, 8'ha5);
    endtask

    // No target answers: missing ACK is reported, nothing stored
    task automatic sc_stranger;
        tgt_addr = 7'h61;
        run_cmd(1'b0, 1'b0, 8'h30, 3'd2, 32'h0000c3c3, 1'b1);
        check(u_tgt.regs[8'h30], 8'h6a);
        tgt_addr = 7'h60;
        run_cmd(1'b1, 1'b0, 8'h30, 3'd0, 32'h0, 1'b0);
        check(o_rd_data, 8'h6a);
    endtask

    // Target held in reset: commands refused, bus stays idle
    task automatic sc_devreset;
        i_dev_reset = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        check(o_hardware_reset_n_pin, 1'b0);
        check(o_cmd_ready, 1'b0);
        i_cmd_valid = 1'b1;
        repeat (40) @(posedge i_clk);
        #1;
        check({o_busy, scl_w, sda_w}, 8'h03);
        i_cmd_valid = 1'b0;
        i_dev_reset = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        check(o_hardware_reset_n_pin, 1'b1);
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        #1;
        i_reset_n = 1'b1;
        sc_burst();
        sc_read();
        sc_hs();
        sc_stranger();
        sc_devreset();
        sc_burst();
        end_of_test();
    end
endmodule
